// ### test/cps_fifo_model.sv
// Behavioural transmit cell FIFOs, one per port, facing the scheduler
module cps_fifo_model (
   input wire logic clk_sys, // System clock
   input wire logic sys_rst, // Synchronous reset
   input wire logic [3:0] add_cell, // Store one more whole cell per set bit
   input wire logic [3:0] tx_rd_strobe, // Read strobes from the scheduler
   input wire logic tx_last_octet, // Last octet of the slot
   output logic [3:0] tx_empty_n // High while a whole cell waits
);
   timeunit 1ns;
   timeprecision 1ps;
   int cells_ff[4];
   logic [3:0] strb_ff;
   logic last_ff;
   // A cell leaves the count as its read begins, so the flag never shows a part cell
   always_ff @(posedge clk_sys) begin
      strb_ff <= tx_rd_strobe;
      last_ff <= tx_last_octet;
      for (int p = 0; p < 4; p++) begin
         if (sys_rst) cells_ff[p] <= 0;
         else cells_ff[p] <= cells_ff[p] + int'(add_cell[p])
            - int'(tx_rd_strobe[p] && (!strb_ff[p] || last_ff));
      end
   end
   // Ports never loaded sit low, as a grounded flag would
   always_comb begin
      for (int p = 0; p < 4; p++) tx_empty_n[p] = cells_ff[p] > 0;
   end
endmodule : cps_fifo_model

// ### test/cps_scheduler_bench.sv
// Self-checking bench for the cell port scheduler against a reference model
module cps_scheduler_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import cps_pkg::*;
   typedef struct packed {logic [3:0] route; logic [7:0] data;} cps_exp_t;
   logic clk_sys = 1'h0;
   logic sys_rst = 1'h1;
   logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'h3, add_cell = 4'h0, tx_empty_n, tx_rd_strobe, rx_wr_strobe;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_idle_slot, tx_last_octet;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [7:0] rx_data_out;
   cps_rx_octet_t rx_in = '0;
   cps_exp_t rq[$], e;
   int n_errors = 0, samples_checked = 0, cells[4], prio[4], rate[4], rx_seen = 0;
   logic rx_v_ff = 1'h0;
   int ptr[4] = '{3, 3, 3, 3};
   logic [31:0] rng = 32'h000161cd;
   logic [31:0] hval[4] = '{32'h0000f000, 32'h0000f000, 32'h0, 32'h0000f000};
   logic [31:0] hmsk[4] = '{32'h0, 32'h00000003, 32'hffffffff, 32'h0};
   logic [3:0] rej = 4'h8;

   cps_scheduler u_cps_scheduler (.clk_sys, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_empty_n, .tx_rd_strobe,
      .tx_idle_slot, .tx_last_octet, .rx_in, .rx_wr_strobe, .rx_data_out);
   cps_fifo_model u_cps_fifo_model (.clk_sys, .sys_rst, .add_cell, .tx_rd_strobe,
      .tx_last_octet, .tx_empty_n);

   initial begin
      forever #12.5 clk_sys = ~clk_sys;
   end
   // *****************
   // Helpers and model
   // *****************
   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction : xs
   task automatic close_out();
      $display("checked %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : close_out
   task automatic chk(input logic ok, input string msg);
      samples_checked++;
      if (ok !== 1'h1) begin
         n_errors++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask : chk
   task automatic tmo(input logic hung, input string msg);
      if (hung) begin
         chk(1'h0, msg);
         close_out();
      end
   endtask : tmo
   task automatic wr(input logic [7:0] idx, input logic [15:0] d, input logic [1:0] er);
      int n;
      s_axi_awaddr <= {22'h0, idx, 2'h0};
      s_axi_wdata <= {16'h0, d};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      for (n = 0; n < 400; n++) begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'h0;
      tmo(n >= 400, "write hang");
      chk(s_axi_bresp === er, "write response");
      @(posedge clk_sys);
   endtask : wr
   task automatic rd(input logic [7:0] idx, input logic [15:0] x, input logic [1:0] er);
      int n;
      s_axi_araddr <= {22'h0, idx, 2'h0};
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      for (n = 0; n < 400; n++) begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'h0;
      tmo(n >= 400, "read hang");
      chk(s_axi_rdata === {16'h0, x} && s_axi_rresp === er, "read data");
      @(posedge clk_sys);
   endtask : rd
   task automatic load(input logic [3:0] m);
      @(posedge clk_sys);
      add_cell <= m;
      for (int p = 0; p < 4; p++) cells[p] += m[p];
      @(posedge clk_sys);
      add_cell <= 4'h0;
   endtask : load
   task automatic slot(output logic [3:0] s);
      int n;
      for (n = 0; n < 60; n++) begin
         @(posedge clk_sys);
         if (tx_last_octet) break;
      end
      tmo(n >= 60, "no slot boundary");
      @(posedge clk_sys);
      s = tx_rd_strobe;
   endtask : slot
   // Highest level first, then the port after the last one granted at that level
   function automatic int pick();
      for (int l = 0; l < 4; l++) begin
         for (int i = 1; i < 5; i++) begin
            int p = (ptr[l] + i) % 4;
            if (prio[p] == l && cells[p] > 0 && rate[p] != 0) begin
               ptr[l] = p;
               return p;
            end
         end
      end
      return -1;
   endfunction : pick
   task automatic tx_step();
      logic [3:0] s;
      int x;
      slot(s);
      x = pick();
      if (x >= 0) cells[x]--;
      chk(s === (x < 0 ? 4'h0 : 4'h1 << x), "granted port");
      chk(tx_idle_slot === (x < 0), "idle slot flag");
   endtask : tx_step
   function automatic logic [3:0] route_of(input logic [31:0] h);
      for (int p = 0; p < 4; p++) route_of[p] = (((h ^ hval[p]) & ~hmsk[p]) == '0) ^ rej[p];
   endfunction : route_of
   task automatic send_cell(input logic [31:0] h);
      logic [7:0] d;
      logic [3:0] r;
      r = route_of(h);
      for (int o = 0; o < 53; o++) begin
         d = o < 4 ? h[31 - 8 * o -: 8] : 8'(xs());
         @(posedge clk_sys);
         rx_in <= '{valid: 1'h1, soc: o == 0, data: d};
         rq.push_back('{route: r, data: d});
      end
      @(posedge clk_sys);
      rx_in <= '0;
   endtask : send_cell
   // Octet n leaves with its route once the design has taken octet n + 4
   always @(posedge clk_sys) rx_v_ff <= rx_in.valid;
   always @(negedge clk_sys) begin
      if (!sys_rst && rx_v_ff) rx_seen++;
      if (!sys_rst && rx_v_ff && rx_seen > 4) begin
         e = rq.pop_front();
         chk(rx_wr_strobe === e.route, "receive route");
         if (e.route != 4'h0) chk(rx_data_out === e.data, "receive octet");
      end else if (!sys_rst) chk(rx_wr_strobe === 4'h0, "stray strobe");
   end
   // *****************
   // Main sequence
   // *****************
   initial begin
      logic [63:0] hw;
      logic [3:0] s;
      int last, cnt;
      repeat (20) @(posedge clk_sys);
      sys_rst <= 1'h0;
      @(posedge clk_sys);
      rd(CPS_IDX_RATE01, 16'h0, CPS_RESP_OKAY);
      rd(CPS_IDX_CFG3, 16'h0, CPS_RESP_OKAY);
      rd(8'h3f, 16'h0, CPS_RESP_SLVERR);
      wr(8'h3f, 16'h1234, CPS_RESP_SLVERR);
      wr(CPS_IDX_RATE01, 16'hffff, CPS_RESP_OKAY);
      wr(CPS_IDX_RATE23, 16'hffff, CPS_RESP_OKAY);
      rd(CPS_IDX_RATE23, 16'hffff, CPS_RESP_OKAY);
      wr(CPS_IDX_FMT_BASE + 8'h2, 16'h0008, CPS_RESP_OKAY);
      wr(CPS_IDX_FMT_BASE + 8'h3, 16'h000c, CPS_RESP_OKAY);
      rd(CPS_IDX_FMT_BASE + 8'h3, 16'h000c, CPS_RESP_OKAY);
      $display("register test done");
      rate = '{255, 255, 255, 255};
      prio = '{0, 0, 2, 3};
      cells = '{0, 0, 0, 0};
      tx_step();
      load(4'hc);
      load(4'hc);
      tx_step();
      load(4'h3);
      load(4'h3);
      repeat (8) tx_step();
      $display("priority test done");
      wr(CPS_IDX_RATE01, 16'h003f, CPS_RESP_OKAY);
      wr(CPS_IDX_RATE23, 16'h0000, CPS_RESP_OKAY);
      repeat (70) load(4'h3);
      last = -1;
      cnt = 0;
      for (int k = 0; k < 256; k++) begin
         slot(s);
         chk(s[3:1] === 3'h0, "disabled port served");
         if (s[0] === 1'h1) begin
            if (last >= 0) chk(k - last == 4, "grant spacing");
            last = k;
            cnt++;
         end
      end
      chk(cnt == 64, "grants per counter cycle");
      $display("rate test done");
      wr(CPS_IDX_CFG3, 16'h8000, CPS_RESP_OKAY);
      for (int i = 0; i < 16; i++) begin
         hw = {hval[i / 4], hmsk[i / 4]};
         wr(CPS_IDX_HDR_BASE + 8'(i), hw[63 - 16 * (i % 4) -: 16], CPS_RESP_OKAY);
      end
      send_cell(32'h0000f000);
      send_cell(32'h0000f002);
      send_cell(xs());
      send_cell(32'h0000f001);
      $display("receive test done");
      close_out();
   end
   initial begin
      repeat (60000) @(posedge clk_sys);
      tmo(1'h1, "run too long");
   end
endmodule : cps_scheduler_bench

// ### verilog/cps_pkg.sv
// Package of constants, register map and carrier types for the cell port scheduler
package cps_pkg;
   // ***************************************************
   // Register indices (byte address is four times index)
   // ***************************************************
   localparam logic [7:0] CPS_IDX_CFG3 = 8'h02;
   localparam logic [7:0] CPS_IDX_RATE23 = 8'h08;
   localparam logic [7:0] CPS_IDX_RATE01 = 8'h09;
   localparam logic [7:0] CPS_IDX_FMT_BASE = 8'h10;
   localparam logic [7:0] CPS_IDX_HDR_BASE = 8'h20;
   localparam logic [7:0] CPS_IDX_STATUS = 8'h30;
   // ***************************************************
   // Field positions and reset values
   // ***************************************************
   localparam int CPS_PRIO_LSB = 2;
   localparam int CPS_REJECT_LSB = 12;
   localparam logic [15:0] CPS_RST_FMT = 16'h0000;
   localparam logic [15:0] CPS_RST_CFG3 = 16'h0000;
   localparam logic [15:0] CPS_RST_RATE = 16'h0000;
   localparam logic [15:0] CPS_RST_HDR = 16'h0000;
   // ***************************************************
   // Cell timing and bus response codes
   // ***************************************************
   localparam int CPS_CELL_OCTETS = 53;
   localparam int CPS_HDR_OCTETS = 4;
   localparam logic [1:0] CPS_RESP_OKAY = 2'h0;
   localparam logic [1:0] CPS_RESP_SLVERR = 2'h2;

   typedef enum logic {CPS_SLOT_IDLE, CPS_SLOT_PORT} cps_slot_t;

   // Corrected received octet stream from the header check logic
   typedef struct packed {
      logic valid;
      logic soc;
      logic [7:0] data;
   } cps_rx_octet_t;
endpackage : cps_pkg

// ### verilog/cps_scheduler.sv
// Transmit port scheduler, rate shaper, receive header router and register slave
module cps_scheduler #(
   parameter int CELL_OCTETS = cps_pkg::CPS_CELL_OCTETS,
   parameter int HDR_OCTETS = cps_pkg::CPS_HDR_OCTETS
) (
   input wire logic clk_sys, // 40 MHz system clock
   input wire logic sys_rst, // Synchronous reset, active high
   input wire logic [31:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [31:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   input wire logic [3:0] tx_empty_n, // Per-port transmit FIFO empty pins
   output logic [3:0] tx_rd_strobe, // Per-port read strobe, one per octet
   output logic tx_idle_slot, // Current slot carries an idle cell
   output logic tx_last_octet, // Last octet of the current slot
   input wire cps_pkg::cps_rx_octet_t rx_in, // Corrected received octets
   output logic [3:0] rx_wr_strobe, // Per-port receive write strobe
   output logic [7:0] rx_data_out // Octet written to addressed ports
);
   import cps_pkg::*;

   // ***************************************************
   // Register storage
   // ***************************************************
   logic [15:0] fmt_ff [4];
   logic [15:0] val_hi_ff [4];
   logic [15:0] val_lo_ff [4];
   logic [15:0] msk_hi_ff [4];
   logic [15:0] msk_lo_ff [4];
   logic [15:0] cfg3_ff, rate23_ff, rate01_ff;

   // ***************************************************
   // AXI4-Lite write channel
   // ***************************************************
   logic aw_held_ff, w_held_ff, awready_ff, wready_ff, bvalid_ff;
   logic [1:0] bresp_ff, wr_port;
   logic [7:0] wr_idx_ff, wr_idx;
   logic [31:0] wdata_ff, wr_data;
   logic [3:0] wstrb_ff, wr_strb;
   logic aw_take, w_take, nxt_aw_held, nxt_w_held, do_write, nxt_bvalid, wr_hit;

   assign aw_take = s_axi_awvalid & awready_ff;
   assign w_take = s_axi_wvalid & wready_ff;
   assign do_write = (aw_held_ff | aw_take) & (w_held_ff | w_take) & ~bvalid_ff;
   assign nxt_aw_held = (aw_held_ff | aw_take) & ~do_write;
   assign nxt_w_held = (w_held_ff | w_take) & ~do_write;
   assign nxt_bvalid = do_write | (bvalid_ff & ~s_axi_bready);
   assign wr_idx = aw_held_ff ? wr_idx_ff : s_axi_awaddr[9:2];
   assign wr_data = w_held_ff ? wdata_ff : s_axi_wdata;
   assign wr_strb = w_held_ff ? wstrb_ff : s_axi_wstrb;
   assign wr_port = wr_idx[3:2];
   assign wr_hit = (wr_idx == CPS_IDX_CFG3) || (wr_idx == CPS_IDX_RATE23)
                || (wr_idx == CPS_IDX_RATE01) || (wr_idx[7:2] == CPS_IDX_FMT_BASE[7:2])
                || (wr_idx[7:4] == CPS_IDX_HDR_BASE[7:4]);

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         aw_held_ff <= 1'b0;
         w_held_ff <= 1'b0;
         awready_ff <= 1'b0;
         wready_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff <= CPS_RESP_OKAY;
         wr_idx_ff <= 8'h00;
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
      end else begin
         aw_held_ff <= nxt_aw_held;
         w_held_ff <= nxt_w_held;
         awready_ff <= ~nxt_aw_held & ~nxt_bvalid;
         wready_ff <= ~nxt_w_held & ~nxt_bvalid;
         bvalid_ff <= nxt_bvalid;
         if (aw_take) begin
            wr_idx_ff <= s_axi_awaddr[9:2];
         end
         if (w_take) begin
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (do_write) begin
            bresp_ff <= wr_hit ? CPS_RESP_OKAY : CPS_RESP_SLVERR;
         end
      end
   end

   // Merge the two low byte lanes into a 16-bit register
   function automatic logic [15:0] cps_merge(input logic [15:0] old, input logic [31:0] d,
                                             input logic [3:0] s);
      cps_merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction : cps_merge

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         cfg3_ff <= CPS_RST_CFG3;
         rate23_ff <= CPS_RST_RATE;
         rate01_ff <= CPS_RST_RATE;
         for (int p = 0; p < 4; p++) begin
            fmt_ff[p] <= CPS_RST_FMT;
            val_hi_ff[p] <= CPS_RST_HDR;
            val_lo_ff[p] <= CPS_RST_HDR;
            msk_hi_ff[p] <= CPS_RST_HDR;
            msk_lo_ff[p] <= CPS_RST_HDR;
         end
      end else if (do_write) begin
         if (wr_idx == CPS_IDX_CFG3) begin
            cfg3_ff <= cps_merge(cfg3_ff, wr_data, wr_strb);
         end
         if (wr_idx == CPS_IDX_RATE23) begin
            rate23_ff <= cps_merge(rate23_ff, wr_data, wr_strb);
         end
         if (wr_idx == CPS_IDX_RATE01) begin
            rate01_ff <= cps_merge(rate01_ff, wr_data, wr_strb);
         end
         if (wr_idx[7:2] == CPS_IDX_FMT_BASE[7:2]) begin
            fmt_ff[wr_idx[1:0]] <= cps_merge(fmt_ff[wr_idx[1:0]], wr_data, wr_strb);
         end
         if (wr_idx[7:4] == CPS_IDX_HDR_BASE[7:4]) begin
            unique case (wr_idx[1:0])
               2'h0: val_hi_ff[wr_port] <= cps_merge(val_hi_ff[wr_port], wr_data, wr_strb);
               2'h1: val_lo_ff[wr_port] <= cps_merge(val_lo_ff[wr_port], wr_data, wr_strb);
               2'h2: msk_hi_ff[wr_port] <= cps_merge(msk_hi_ff[wr_port], wr_data, wr_strb);
               2'h3: msk_lo_ff[wr_port] <= cps_merge(msk_lo_ff[wr_port], wr_data, wr_strb);
            endcase
         end
      end
   end

   // ***************************************************
   // Transmit scheduler
   // ***************************************************
   logic [3:0] empty_s1_ff, empty_s2_ff, elig, strobe_ff;
   logic [7:0] master_cnt_ff, cnt_rev;
   logic [5:0] oct_cnt_ff;
   logic boundary, last_oct_ff, any_elig;
   logic [7:0] rate [4];
   logic [1:0] prio_eff_ff [4], last_ff [4];
   logic [1:0] sel_ff, best_lvl, grant;
   cps_slot_t slot_ff;

   assign rate[0] = rate01_ff[7:0];
   assign rate[1] = rate01_ff[15:8];
   assign rate[2] = rate23_ff[7:0];
   assign rate[3] = rate23_ff[15:8];
   assign boundary = (oct_cnt_ff == 6'(CELL_OCTETS - 1));
   assign cnt_rev = {<<{master_cnt_ff}};

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         empty_s1_ff <= 4'h0;
         empty_s2_ff <= 4'h0;
      end else begin
         empty_s1_ff <= tx_empty_n;
         empty_s2_ff <= empty_s1_ff;
      end
   end

   for (genvar p = 0; p < 4; p++) begin : g_port
      // Rate zero masks the flag; bit-reversed count spreads permitted states
      assign elig[p] = empty_s2_ff[p] && (rate[p] != 8'h00)
                       && (cnt_rev <= rate[p]);
      always_ff @(posedge clk_sys) begin
         if (sys_rst) begin
            prio_eff_ff[p] <= CPS_RST_FMT[CPS_PRIO_LSB +: 2];
         end else if (!elig[p] && !(slot_ff == CPS_SLOT_PORT && sel_ff == 2'(p))) begin
            prio_eff_ff[p] <= fmt_ff[p][CPS_PRIO_LSB +: 2];
         end
      end
   end

   always_comb begin
      best_lvl = 2'h3;
      any_elig = 1'b0;
      grant = 2'h0;
      for (int l = 3; l >= 0; l--) begin
         for (int p = 0; p < 4; p++) begin
            if (elig[p] && prio_eff_ff[p] == 2'(l)) begin
               best_lvl = 2'(l);
               any_elig = 1'b1;
            end
         end
      end
      for (int k = 4; k >= 1; k--) begin
         if (elig[2'(last_ff[best_lvl] + 2'(k))] &&
             prio_eff_ff[2'(last_ff[best_lvl] + 2'(k))] == best_lvl) begin
            grant = 2'(last_ff[best_lvl] + 2'(k));
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         oct_cnt_ff <= 6'h00;
         master_cnt_ff <= 8'h00;
         slot_ff <= CPS_SLOT_IDLE;
         sel_ff <= 2'h0;
         strobe_ff <= 4'h0;
         last_oct_ff <= 1'b0;
         for (int l = 0; l < 4; l++) begin
            last_ff[l] <= 2'h3;
         end
      end else begin
         last_oct_ff <= (oct_cnt_ff == 6'(CELL_OCTETS - 2));
         if (boundary) begin
            oct_cnt_ff <= 6'h00;
            master_cnt_ff <= master_cnt_ff + 8'h01;
            // Decision only at cell edges so a cell is never split
            if (any_elig) begin
               slot_ff <= CPS_SLOT_PORT;
               sel_ff <= grant;
               strobe_ff <= 4'h1 << grant;
               last_ff[best_lvl] <= grant;
            end else begin
               slot_ff <= CPS_SLOT_IDLE;
               strobe_ff <= 4'h0;
            end
         end else begin
            oct_cnt_ff <= oct_cnt_ff + 6'h01;
         end
      end
   end

   assign tx_rd_strobe = strobe_ff;
   assign tx_idle_slot = (slot_ff == CPS_SLOT_IDLE);
   assign tx_last_octet = last_oct_ff;

   // ***************************************************
   // Receive header screening
   // ***************************************************
   logic [5:0] rx_pos_ff;
   logic [23:0] hdr_ff;
   logic [7:0] dly_ff [HDR_OCTETS];
   logic [3:0] route_ff;
   logic [31:0] hdr_now;
   logic [3:0] match;
   logic decide;
   logic [5:0] pos_now;
   logic [3:0] rx_strobe_ff;
   logic [7:0] rx_data_ff;

   assign pos_now = rx_in.soc ? 6'h00 : rx_pos_ff;
   assign decide = rx_in.valid && (pos_now == 6'(HDR_OCTETS - 1));
   assign hdr_now = {hdr_ff, rx_in.data};

   for (genvar p = 0; p < 4; p++) begin : g_match
      assign match[p] = (((hdr_now ^ {val_hi_ff[p], val_lo_ff[p]}) &
                         ~{msk_hi_ff[p], msk_lo_ff[p]}) == 32'h0000_0000);
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rx_pos_ff <= 6'h00;
         hdr_ff <= 24'h00_0000;
         route_ff <= 4'h0;
         rx_strobe_ff <= 4'h0;
         rx_data_ff <= 8'h00;
         for (int i = 0; i < HDR_OCTETS; i++) begin
            dly_ff[i] <= 8'h00;
         end
      end else begin
         rx_strobe_ff <= 4'h0;
         if (rx_in.valid) begin
            rx_pos_ff <= (pos_now == 6'(CELL_OCTETS - 1)) ? 6'h00 : pos_now + 6'h01;
            hdr_ff <= hdr_now[23:0];
            // Leading octets wait in the delay line until routing is known
            dly_ff[0] <= rx_in.data;
            for (int i = 1; i < HDR_OCTETS; i++) begin
               dly_ff[i] <= dly_ff[i - 1];
            end
            rx_data_ff <= dly_ff[HDR_OCTETS - 1];
            rx_strobe_ff <= route_ff;
            if (decide) begin
               route_ff <= match ^ cfg3_ff[CPS_REJECT_LSB +: 4];
            end
         end
      end
   end

   assign rx_wr_strobe = rx_strobe_ff;
   assign rx_data_out = rx_data_ff;

   // ***************************************************
   // AXI4-Lite read channel
   // ***************************************************
   logic arready_ff, rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;
   logic [7:0] rd_idx;
   logic [15:0] rd_val;
   logic rd_hit;

   assign rd_idx = s_axi_araddr[9:2];

   always_comb begin
      rd_val = 16'h0000;
      rd_hit = 1'b1;
      if (rd_idx == CPS_IDX_CFG3) begin
         rd_val = cfg3_ff;
      end else if (rd_idx == CPS_IDX_RATE23) begin
         rd_val = rate23_ff;
      end else if (rd_idx == CPS_IDX_RATE01) begin
         rd_val = rate01_ff;
      end else if (rd_idx[7:2] == CPS_IDX_FMT_BASE[7:2]) begin
         rd_val = fmt_ff[rd_idx[1:0]];
      end else if (rd_idx[7:4] == CPS_IDX_HDR_BASE[7:4]) begin
         unique case (rd_idx[1:0])
            2'h0: rd_val = val_hi_ff[rd_idx[3:2]];
            2'h1: rd_val = val_lo_ff[rd_idx[3:2]];
            2'h2: rd_val = msk_hi_ff[rd_idx[3:2]];
            2'h3: rd_val = msk_lo_ff[rd_idx[3:2]];
         endcase
      end else if (rd_idx == CPS_IDX_STATUS) begin
         rd_val = {master_cnt_ff, 3'h0, tx_idle_slot, 2'h0, sel_ff};
      end else begin
         rd_hit = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= CPS_RESP_OKAY;
      end else if (s_axi_arvalid && arready_ff) begin
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b1;
         rdata_ff <= {16'h0000, rd_val};
         rresp_ff <= rd_hit ? CPS_RESP_OKAY : CPS_RESP_SLVERR;
      end else if (rvalid_ff) begin
         rvalid_ff <= ~s_axi_rready;
         arready_ff <= s_axi_rready;
      end else begin
         arready_ff <= 1'b1;
      end
   end

   assign s_axi_awready = awready_ff;
   assign s_axi_wready = wready_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;

   // ***************************************************
   // Assertions
   // ***************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   a_strobe_onehot: assert property ($onehot0(strobe_ff))
      else $error("more than one read strobe");
   a_cell_whole: assert property (!boundary |=> $stable(strobe_ff))
      else $error("strobe changed inside a cell");
   a_count_step: assert property (boundary |=>
      master_cnt_ff == $past(master_cnt_ff) + 8'h01)
      else $error("cell counter did not step");
   a_grant_rate: assert property (boundary && any_elig |-> rate[grant] != 8'h00
      ##1 slot_ff == CPS_SLOT_PORT)
      else $error("disabled port granted");
   a_grant_window: assert property (boundary && any_elig |-> cnt_rev <= rate[grant])
      else $error("port granted outside its window");
   a_level_best: assert property (boundary && any_elig |->
      !(elig[0] && prio_eff_ff[0] < prio_eff_ff[grant]) &&
      !(elig[1] && prio_eff_ff[1] < prio_eff_ff[grant]) &&
      !(elig[2] && prio_eff_ff[2] < prio_eff_ff[grant]) &&
      !(elig[3] && prio_eff_ff[3] < prio_eff_ff[grant]))
      else $error("lower level served over higher");
   a_idle_slot: assert property (boundary && !any_elig |=> strobe_ff == 4'h0)
      else $error("strobe in idle slot");
   a_prio_static: assert property ($changed(prio_eff_ff[2]) |-> $past(!elig[2]))
      else $error("priority changed on active port");
   a_rx_addressed: assert property (|rx_strobe_ff |-> $past(rx_in.valid) &&
      (rx_strobe_ff & ~$past(route_ff)) == 4'h0)
      else $error("strobe to unaddressed port");
   a_rx_reject: assert property (decide |=>
      route_ff == ($past(match) ^ $past(cfg3_ff[15:12])))
      else $error("route does not follow match and reject");

   c_port_cell: cover property (boundary && any_elig ##1 !boundary [*8]);
   c_idle_cell: cover property (boundary && !any_elig);
   c_broadcast: cover property (rx_strobe_ff == 4'hf);
endmodule : cps_scheduler
